/* inc/readout_params.svh */
// timing constants for the sensor row/column sequencer
// assumes a 4 ns core clock; every count rounds a least time up to whole cycles
`ifndef READOUT_PARAMS_SVH
`define READOUT_PARAMS_SVH

`define CLK_PERIOD_NS   4
`define NS_TO_CYC(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// row sequence times in ns
`define ROW_CLK_NS      500
`define SEL_WAIT_NS     1400
`define SAMPLE_NS       400
`define RST_GAP_NS      100
`define RST_WIDTH_NS    100
`define R_LEAD_NS       400
`define LR_LEAD_NS      100
`define LR_MARGIN_NS    100
`define CAL_DELAY_NS    2000
`define CAL_WIDTH_NS    1000

// start address load times in ns
`define ADDR_SETUP_NS   10
`define LOAD_WIDTH_NS   20
`define ADDR_HOLD_NS    10

// column times in ns; sync lag in core cycles
`define COL_HIGH_NS     40
`define COL_LOW_NS      160
`define ADC_VALID_NS    125
`define SYNC_LAG_CYC    2

// derived cycle counts
`define ROW_CLK_CYC     `NS_TO_CYC(`ROW_CLK_NS)
`define SEL_WAIT_CYC    `NS_TO_CYC(`SEL_WAIT_NS)
`define SAMPLE_CYC      `NS_TO_CYC(`SAMPLE_NS)
`define RST_GAP_CYC     `NS_TO_CYC(`RST_GAP_NS)
`define RST_WIDTH_CYC   `NS_TO_CYC(`RST_WIDTH_NS)
`define R_LEAD_CYC      `NS_TO_CYC(`R_LEAD_NS)
`define LR_LEAD_CYC     `NS_TO_CYC(`LR_LEAD_NS)
`define LR_MARGIN_CYC   `NS_TO_CYC(`LR_MARGIN_NS)
`define CAL_ON_CYC      `NS_TO_CYC(`CAL_DELAY_NS)
`define CAL_OFF_CYC     (`CAL_ON_CYC + `NS_TO_CYC(`CAL_WIDTH_NS))
`define ADDR_SETUP_CYC  `NS_TO_CYC(`ADDR_SETUP_NS)
`define LOAD_WIDTH_CYC  `NS_TO_CYC(`LOAD_WIDTH_NS)
`define ADDR_HOLD_CYC   `NS_TO_CYC(`ADDR_HOLD_NS)
`define COL_HIGH_CYC    `NS_TO_CYC(`COL_HIGH_NS)
`define COL_LOW_CYC     `NS_TO_CYC(`COL_LOW_NS)
`define ADC_SAMPLE_CYC  (`NS_TO_CYC(`ADC_VALID_NS) + `SYNC_LAG_CYC)

`endif

/* inc/readout_pkg.sv */
// types shared by the sensor readout sequencer and its helpers
// assumes the timing header supplies all constants
package readout_pkg;

  typedef logic [8:0]  addr_t;
  typedef logic [9:0]  pix_t;
  typedef logic [9:0]  count_t;
  typedef logic [15:0] tick_t;

  typedef enum logic [4:0] {
    IDLE, LD_SETUP, LD_PULSE, LD_HOLD, ROW_CLK, SEL_WAIT, S_HI, RST1_GAP,
    RST1, R_WAIT, R_HI, LR_GAP, LR_PRE, RST2, LR_POST, COL_HI, COL_LO
  } seq_state_t;

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
  } sync_t;

  typedef struct packed {
    tick_t cnt;
  } timer_t;

  typedef struct packed {
    seq_state_t state;
    logic       ld_y;
    count_t     row;
    count_t     pix;
    logic       x_valid;
    addr_t      x_loaded;
    logic       cal_run;
    count_t     cal_cnt;
    logic       rd_clk;
    logic       sh_clk;
    logic       rd_pre;
    logic       sh_pre;
    logic       samp_sig;
    logic       samp_rst;
    logic       rst;
    logic       lr;
    logic       col_clk;
    logic       col_pre;
    logic       ld_x;
    logic       ld_yp;
    addr_t      addr;
    logic       trim;
    logic       arr_en;
    pix_t       pix_data;
    logic       pix_valid;
    logic       frame_start;
    logic       busy;
    logic [2:0] end_prev;
    logic [2:0] end_pulse;
  } ctl_t;

endpackage : readout_pkg

/* logic/pin_sync.sv */
// two-flop synchroniser for the sensor's returning pins
// assumes nothing but the core clock; stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // pins in, synchronised out
  input  wire logic [12:0] pins_i,
  output logic      [12:0] pins_o
);
  import readout_pkg::*;

  sync_t st;
  sync_t next_st;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = pins_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign pins_o = st.s2;

endmodule : pin_sync

/* logic/phase_timer.sv */
// down counter that times each phase of the sequencer
// assumes a load count of at least one; done marks the last cycle of a phase
`timescale 1ns/1ps
module phase_timer
(
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_n_i,
  // control
  input  wire logic               load_i,
  input  wire readout_pkg::tick_t count_i,
  // status
  output readout_pkg::tick_t      count_o,
  output logic                    done_o
);
  import readout_pkg::*;

  timer_t st;
  timer_t next_st;

  always_comb
  begin
    next_st = st;
    if (load_i)
      next_st.cnt = count_i - 16'h0001;
    else if (st.cnt != 16'h0000)
      next_st.cnt = st.cnt - 16'h0001;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign count_o = st.cnt;
  assign done_o  = (st.cnt == 16'h0000);

endmodule : phase_timer

/* logic/image_sensor_readout_sequencer.sv */
// controller that drives row, column, load and offset pins of a line-scan
// sensor with electronic shutter and collects its converted pixels.
// assumes a 250 MHz core clock, stable window settings while running, and
// sensor outputs that are asynchronous to this clock.
//
// Function
// - read and shutter presets once per frame, same row slot; both in row 0 when delay is 0 or not below height.
// - shutter preset leads read preset by the delay line count.
// - offset trim on the first row, 2 us after read preset.
// - wait at least 1.4 us after row selection before any pixel.
// - read no pixels between first sample rise and row-side select fall.
// - first sample falls at least 1.8 us after row clock fall.
// - first sample falls at least 1.8 us after a read preset.
// - each sampling pulse lasts at least 0.4 us.
// - row-side select overlaps second reset both sides; reset at least 0.1 us.
// - second sample falls at least 0.8 us after reset falls.
// - row reset rises at least 20 ns after first sample falls.
// - row clock falls no earlier than row-side select falls.
// - offset trim at least 100 ns wide, once per frame.
// - row-side select rises at least 40 ns after second sample falls.
// - first sample falls at least 0.1 us after row clock rises.
// - address on shared bus, load strobe at least 20 ns, used at preset.
// - load X in row idle, Y before the frame; skip unchanged X values, Y is loaded every frame.
// - offset trim high routes dark reference; done each frame.
// - pointers wrap to the first window row through their presets.
`timescale 1ns/1ps
`include "readout_params.svh"
module image_sensor_readout_sequencer
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // user control
  input  wire logic                run_i,
  input  wire readout_pkg::addr_t  x_start_i,
  input  wire readout_pkg::addr_t  y_start_i,
  input  wire readout_pkg::count_t width_i,
  input  wire readout_pkg::count_t height_i,
  input  wire readout_pkg::count_t delay_lines_i,
  // user results
  output readout_pkg::pix_t        pixel_data_o,
  output logic                     pixel_valid_o,
  output logic                     frame_start_o,
  output logic                     busy_o,
  output logic                     column_end_pulse_o,
  output logic                     read_row_end_pulse_o,
  output logic                     shutter_row_end_pulse_o,
  // sensor row pins
  output logic                     read_row_clock_o,
  output logic                     shutter_row_clock_o,
  output logic                     read_row_preset_o,
  output logic                     shutter_row_preset_o,
  output logic                     sample_signal_o,
  output logic                     sample_reset_o,
  output logic                     row_reset_o,
  output logic                     row_side_select_o,
  // sensor column and converter pins
  output logic                     column_clock_o,
  output logic                     column_preset_o,
  output logic                     adc_clock_o,
  // sensor load and misc pins
  output readout_pkg::addr_t       start_addr_o,
  output logic                     x_start_load_o,
  output logic                     y_start_load_o,
  output logic                     offset_trim_o,
  output logic                     array_enable_o,
  // sensor returns
  input  wire logic                column_chain_end_flag_i,
  input  wire logic                read_row_end_flag_i,
  input  wire logic                shutter_row_end_flag_i,
  input  wire readout_pkg::pix_t   adc_data_i
);
  import readout_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // row in which the shutter preset goes so that it leads by delay rows
  function automatic count_t shutter_row(count_t h, count_t d);
    count_t r;
    r = 10'h000;
    if (d != 10'h000 && d < h)
      r = h - d;
    return r;
  endfunction : shutter_row

  // start a row: both row clocks rise together, presets ride on them
  function automatic ctl_t row_enter(ctl_t s, count_t shut);
    ctl_t r;
    r             = s;
    r.state       = ROW_CLK;
    r.rd_clk      = 1'b1;
    r.sh_clk      = 1'b1;
    r.rd_pre      = (s.row == 10'h000);
    r.sh_pre      = (s.row == shut);
    r.frame_start = (s.row == 10'h000);
    return r;
  endfunction : row_enter

  // ----------------------------------------------------------------
  // input synchroniser and phase timer
  // ----------------------------------------------------------------

  logic [12:0] in_sync;
  logic        tmr_load;
  tick_t       tmr_count;
  tick_t       tmr_cnt;
  logic        tmr_done;
  count_t      shut;

  pin_sync u_sync
  (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .pins_i     ({column_chain_end_flag_i, read_row_end_flag_i,
                  shutter_row_end_flag_i, adc_data_i}),
    .pins_o     (in_sync)
  );

  phase_timer u_timer
  (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .load_i     (tmr_load),
    .count_i    (tmr_count),
    .count_o    (tmr_cnt),
    .done_o     (tmr_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------

  ctl_t st;
  ctl_t next_st;

  assign shut = shutter_row(height_i, delay_lines_i);

  always_comb
  begin
    next_st             = st;
    tmr_load            = 1'b0;
    tmr_count           = 16'h0001;
    next_st.pix_valid   = 1'b0;
    next_st.frame_start = 1'b0;
    next_st.arr_en      = 1'b1;
    next_st.end_prev    = in_sync[12:10];
    next_st.end_pulse   = in_sync[12:10] & ~st.end_prev;

    if (st.cal_run)
    begin
      next_st.cal_cnt = st.cal_cnt + 10'h001;
      if (st.cal_cnt == 10'(`CAL_ON_CYC - 1))
        next_st.trim = 1'b1;
      if (st.cal_cnt == 10'(`CAL_OFF_CYC - 1))
      begin
        next_st.trim    = 1'b0;
        next_st.cal_run = 1'b0;
      end
    end

    unique case (st.state)
      IDLE:
      begin
        if (run_i)
        begin
          next_st.row   = 10'h000;
          next_st.ld_y  = 1'b1;
          next_st.addr  = y_start_i;
          next_st.state = LD_SETUP;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`ADDR_SETUP_CYC);
        end
      end
      LD_SETUP:
      begin
        if (tmr_done)
        begin
          next_st.ld_yp = st.ld_y;
          next_st.ld_x  = !st.ld_y;
          next_st.state = LD_PULSE;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`LOAD_WIDTH_CYC);
        end
      end
      LD_PULSE:
      begin
        if (tmr_done)
        begin
          next_st.ld_yp = 1'b0;
          next_st.ld_x  = 1'b0;
          next_st.state = LD_HOLD;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`ADDR_HOLD_CYC);
        end
      end
      LD_HOLD:
      begin
        if (tmr_done && st.ld_y)
        begin
          next_st   = row_enter(next_st, shut);
          tmr_load  = 1'b1;
          tmr_count = 16'(`ROW_CLK_CYC);
        end
        else if (tmr_done)
        begin
          next_st.x_loaded = st.addr;
          next_st.x_valid  = 1'b1;
          next_st.col_clk  = 1'b1;
          next_st.col_pre  = 1'b1;
          next_st.state    = COL_HI;
          tmr_load         = 1'b1;
          tmr_count        = 16'(`COL_HIGH_CYC);
        end
      end
      ROW_CLK:
      begin
        if (tmr_done)
        begin
          next_st.rd_clk = 1'b0;
          next_st.sh_clk = 1'b0;
          next_st.rd_pre = 1'b0;
          next_st.sh_pre = 1'b0;
          if (st.rd_pre)
          begin
            next_st.cal_run = 1'b1;
            next_st.cal_cnt = 10'h000;
          end
          next_st.state = SEL_WAIT;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`SEL_WAIT_CYC);
        end
      end
      SEL_WAIT:
      begin
        if (tmr_done)
        begin
          next_st.samp_sig = 1'b1;
          next_st.state    = S_HI;
          tmr_load         = 1'b1;
          tmr_count        = 16'(`SAMPLE_CYC);
        end
      end
      S_HI:
      begin
        if (tmr_done)
        begin
          next_st.samp_sig = 1'b0;
          next_st.state    = RST1_GAP;
          tmr_load         = 1'b1;
          tmr_count        = 16'(`RST_GAP_CYC);
        end
      end
      RST1_GAP:
      begin
        if (tmr_done)
        begin
          next_st.rst   = 1'b1;
          next_st.state = RST1;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`RST_WIDTH_CYC);
        end
      end
      RST1:
      begin
        if (tmr_done)
        begin
          next_st.rst   = 1'b0;
          next_st.state = R_WAIT;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`R_LEAD_CYC);
        end
      end
      R_WAIT:
      begin
        if (tmr_done)
        begin
          next_st.samp_rst = 1'b1;
          next_st.state    = R_HI;
          tmr_load         = 1'b1;
          tmr_count        = 16'(`SAMPLE_CYC);
        end
      end
      R_HI:
      begin
        if (tmr_done)
        begin
          next_st.samp_rst = 1'b0;
          next_st.state    = LR_GAP;
          tmr_load         = 1'b1;
          tmr_count        = 16'(`LR_LEAD_CYC);
        end
      end
      LR_GAP:
      begin
        if (tmr_done)
        begin
          next_st.lr    = 1'b1;
          next_st.state = LR_PRE;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`LR_MARGIN_CYC);
        end
      end
      LR_PRE:
      begin
        if (tmr_done)
        begin
          next_st.rst   = 1'b1;
          next_st.state = RST2;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`RST_WIDTH_CYC);
        end
      end
      RST2:
      begin
        if (tmr_done)
        begin
          next_st.rst   = 1'b0;
          next_st.state = LR_POST;
          tmr_load      = 1'b1;
          tmr_count     = 16'(`LR_MARGIN_CYC);
        end
      end
      LR_POST:
      begin
        if (tmr_done)
        begin
          next_st.lr  = 1'b0;
          next_st.pix = 10'h000;
          tmr_load    = 1'b1;
          if (!st.x_valid || st.x_loaded != x_start_i)
          begin
            next_st.ld_y  = 1'b0;
            next_st.addr  = x_start_i;
            next_st.state = LD_SETUP;
            tmr_count     = 16'(`ADDR_SETUP_CYC);
          end
          else
          begin
            next_st.col_clk = 1'b1;
            next_st.col_pre = 1'b1;
            next_st.state   = COL_HI;
            tmr_count       = 16'(`COL_HIGH_CYC);
          end
        end
      end
      COL_HI:
      begin
        if (tmr_done)
        begin
          next_st.col_clk = 1'b0;
          next_st.col_pre = 1'b0;
          next_st.state   = COL_LO;
          tmr_load        = 1'b1;
          tmr_count       = 16'(`COL_LOW_CYC);
        end
      end
      COL_LO:
      begin
        if (tmr_cnt == 16'(`COL_LOW_CYC - 1 - `ADC_SAMPLE_CYC))
        begin
          next_st.pix_data  = in_sync[9:0];
          next_st.pix_valid = 1'b1;
        end
        if (tmr_done)
        begin
          next_st.pix = st.pix + 10'h001;
          tmr_load    = 1'b1;
          if (10'(st.pix + 10'h001) != width_i)
          begin
            next_st.col_clk = 1'b1;
            next_st.state   = COL_HI;
            tmr_count       = 16'(`COL_HIGH_CYC);
          end
          else if (st.row == 10'(height_i - 10'h001))
          begin
            next_st.row   = 10'h000;
            next_st.ld_y  = 1'b1;
            next_st.addr  = y_start_i;
            next_st.state = run_i ? LD_SETUP : IDLE;
            tmr_count     = 16'(`ADDR_SETUP_CYC);
          end
          else
          begin
            next_st.row = st.row + 10'h001;
            next_st     = row_enter(next_st, shut);
            tmr_count   = 16'(`ROW_CLK_CYC);
          end
        end
      end
    endcase

    next_st.busy = (next_st.state != IDLE);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs, each straight from the state register
  // ----------------------------------------------------------------

  assign pixel_data_o            = st.pix_data;
  assign pixel_valid_o           = st.pix_valid;
  assign frame_start_o           = st.frame_start;
  assign busy_o                  = st.busy;
  assign column_end_pulse_o      = st.end_pulse[2];
  assign read_row_end_pulse_o    = st.end_pulse[1];
  assign shutter_row_end_pulse_o = st.end_pulse[0];
  assign read_row_clock_o        = st.rd_clk;
  assign shutter_row_clock_o     = st.sh_clk;
  assign read_row_preset_o       = st.rd_pre;
  assign shutter_row_preset_o    = st.sh_pre;
  assign sample_signal_o         = st.samp_sig;
  assign sample_reset_o          = st.samp_rst;
  assign row_reset_o             = st.rst;
  assign row_side_select_o       = st.lr;
  assign column_clock_o          = st.col_clk;
  assign column_preset_o         = st.col_pre;
  // converter clock shares the column clock flop, so its fall marks each pixel
  assign adc_clock_o             = st.col_clk;
  assign start_addr_o            = st.addr;
  assign x_start_load_o          = st.ld_x;
  assign y_start_load_o          = st.ld_yp;
  assign offset_trim_o           = st.trim;
  assign array_enable_o          = st.arr_en;

endmodule : image_sensor_readout_sequencer

/* tb/sensor_model.sv */
// sensor model: start registers, row and column pointers, converter data
// assumes the sequencer's pin timing; the bench may lower lag_ns
`timescale 1ns/1ps
module sensor_model
(
  // row pins
  input  wire logic               row_clk_i,
  input  wire logic               rd_pre_i,
  input  wire logic               sh_pre_i,
  // column pins
  input  wire logic               col_clk_i,
  input  wire logic               col_pre_i,
  input  wire logic               adc_clk_i,
  // load and misc pins
  input  wire readout_pkg::addr_t addr_i,
  input  wire logic               x_ld_i,
  input  wire logic               y_ld_i,
  input  wire logic               trim_i,
  input  wire logic               arr_en_i,
  // returns
  output logic                    col_end_o,
  output logic                    rd_end_o,
  output logic                    sh_end_o,
  output readout_pkg::pix_t       data_o
);
  import readout_pkg::*;
  addr_t x_reg = 0, y_reg = 0, x_ptr = 0, y_ptr = 0, s_ptr = 0;
  logic  x_hold = 0, y_hold = 0, s_hold = 0;
  int    lag_ns = 125;
  initial data_o = 10'h000;
  always @(negedge x_ld_i) x_reg = addr_i;
  always @(negedge y_ld_i) y_reg = addr_i;
  always @(posedge rd_pre_i) {y_ptr, y_hold} = {y_reg, 1'b1};
  always @(posedge sh_pre_i) {s_ptr, s_hold} = {y_reg, 1'b1};
  always @(posedge col_pre_i) {x_ptr, x_hold} = {x_reg, 1'b1};
  always @(negedge row_clk_i)
  begin
    if (!y_hold) y_ptr++;
    if (!s_hold) s_ptr++;
    {y_hold, s_hold} = 2'h0;
  end
  always @(negedge col_clk_i)
  begin
    if (!x_hold) x_ptr++;
    x_hold = 1'b0;
  end
  // data late
  // the old value is inverted first: an unsettled bus never repeats the last pixel
  always @(negedge adc_clk_i)
  begin
    data_o = ~data_o;
    #(lag_ns);
    data_o = (arr_en_i && !trim_i) ? {y_ptr[4:0], x_ptr[4:0]} : 10'h000;
  end
  assign col_end_o = x_ptr == 9'h1FF;
  assign rd_end_o = y_ptr == 9'h1FF;
  assign sh_end_o = s_ptr == 9'h1FF;
endmodule : sensor_model

/* tb/readout_chk.sv */
// checker: row pin timing of the readout sequencer, in core cycles
// assumes it is bound to the sequencer top; reset async active low
`timescale 1ns/1ps
module readout_chk
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // watched pins
  input wire logic read_row_clock_o,
  input wire logic shutter_row_clock_o,
  input wire logic read_row_preset_o,
  input wire logic sample_signal_o,
  input wire logic sample_reset_o,
  input wire logic row_reset_o,
  input wire logic row_side_select_o,
  input wire logic column_clock_o,
  input wire logic offset_trim_o,
  input wire logic x_start_load_o,
  input wire logic y_start_load_o,
  input wire logic pixel_valid_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_CLK_PAIR: assert property (read_row_clock_o == shutter_row_clock_o)
    else $error("row clocks differ");
  AST_S_AFTER_ROW: assert property ($fell(sample_signal_o) |->
    $past(read_row_clock_o, 451) && !$past(read_row_clock_o, 450)) else $error("sample early");
  AST_S_WIDTH: assert property ($rose(sample_signal_o) |->
    ##99 sample_signal_o ##1 !sample_signal_o) else $error("sample width");
  AST_RST_GAP: assert property ($fell(sample_signal_o) |-> ##25 $rose(row_reset_o))
    else $error("reset gap");
  AST_R_AFTER_RST: assert property ($fell(sample_reset_o) |->
    $past(row_reset_o, 201) && !$past(row_reset_o, 200)) else $error("second sample early");
  AST_SEL_AFTER_R: assert property ($fell(sample_reset_o) |-> ##25 $rose(row_side_select_o))
    else $error("select gap");
  AST_SEL_OVERLAP: assert property ($rose(row_side_select_o) |-> ##25 $rose(row_reset_o)
    ##25 $fell(row_reset_o) ##25 $fell(row_side_select_o)) else $error("select overlap");
  AST_NO_PIX_INIT: assert property ((sample_signal_o || sample_reset_o ||
    row_reset_o || row_side_select_o) |-> !column_clock_o) else $error("pixel during row init");
  AST_TRIM_DELAY: assert property ($fell(read_row_preset_o) |->
    ##[499:501] $rose(offset_trim_o)) else $error("trim delay");
  AST_LOAD_WIDTH: assert property ($rose(y_start_load_o) |->
    y_start_load_o[*5] ##1 !y_start_load_o) else $error("load strobe width");
  cover property (pixel_valid_o);
  cover property ($rose(x_start_load_o));
  cover property ($rose(offset_trim_o));
endmodule : readout_chk

bind image_sensor_readout_sequencer readout_chk u_chk
(
  .core_clk_i, .reset_n_i, .read_row_clock_o, .shutter_row_clock_o, .read_row_preset_o,
  .sample_signal_o, .sample_reset_o, .row_reset_o, .row_side_select_o, .column_clock_o,
  .offset_trim_o, .x_start_load_o, .y_start_load_o, .pixel_valid_o
);

/* tb/testbench.sv */
// testbench: sequencer against the behavioural sensor, one frame a scenario
// assumes a 250 MHz core clock and the checker bound to the sequencer
`timescale 1ns/1ps
module testbench;
  import readout_pkg::*;
  logic   core_clk_i = 0, reset_n_i = 0, run_i = 0;
  addr_t  x_start_i = 0, y_start_i = 0, start_addr_o;
  count_t width_i = 1, height_i = 1, delay_lines_i = 0;
  pix_t   pixel_data_o, adc_data_i;
  logic   pixel_valid_o, frame_start_o, busy_o, column_end_pulse_o, read_row_end_pulse_o;
  logic   shutter_row_end_pulse_o, read_row_clock_o, shutter_row_clock_o, read_row_preset_o;
  logic   shutter_row_preset_o, sample_signal_o, sample_reset_o, row_reset_o, row_side_select_o;
  logic   column_clock_o, column_preset_o, adc_clock_o, x_start_load_o, y_start_load_o;
  logic   offset_trim_o, array_enable_o, column_chain_end_flag_i, read_row_end_flag_i;
  logic   shutter_row_end_flag_i;
  int     n_errors = 0;
  int     check_count = 0;

  image_sensor_readout_sequencer uut (.*);

  sensor_model sensor
  (
    .row_clk_i(read_row_clock_o), .rd_pre_i(read_row_preset_o), .sh_pre_i(shutter_row_preset_o),
    .col_clk_i(column_clock_o), .col_pre_i(column_preset_o), .adc_clk_i(adc_clock_o),
    .addr_i(start_addr_o), .x_ld_i(x_start_load_o), .y_ld_i(y_start_load_o),
    .trim_i(offset_trim_o), .arr_en_i(array_enable_o), .col_end_o(column_chain_end_flag_i),
    .rd_end_o(read_row_end_flag_i), .sh_end_o(shutter_row_end_flag_i), .data_o(adc_data_i)
  );

  initial
  begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  // ----------
  // checking
  // ----------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // ----------
  // scenarios
  // ----------
  // release was applied at an edge that still saw reset, so the flops wake one edge later
  task automatic reset_test;
    @(negedge core_clk_i);
    check("array_enable_first", 0, array_enable_o);
    @(negedge core_clk_i);
    check("array_enable", 1, array_enable_o);
    check("busy", 0, busy_o);
    check("read_preset_idle", 0, read_row_preset_o);
    $display("reset test done");
  endtask : reset_test

  // one frame; run_i drops at once, so a second frame must not follow
  task automatic frame_test(input addr_t xs, ys, input count_t w, h, d, input int ends);
    int   row = 0, col = 0, npix = 0, nfs = 0, nxl = 0, nyl = 0, ntr = 0, nend = 0;
    int   sh = (d == 0 || d >= h) ? 0 : int'(h - d);
    logic [3:0] prev = 4'h0;
    logic [3:0] cur;
    addr_t ey, ex;
    @(posedge core_clk_i);
    x_start_i <= xs;
    y_start_i <= ys;
    width_i <= w;
    height_i <= h;
    delay_lines_i <= d;
    run_i <= 1'b1;
    @(posedge core_clk_i);
    run_i <= 1'b0;
    for (int i = 0; i < 6000 && (i < 20 || busy_o === 1'b1); i++)
    begin
      @(negedge core_clk_i);
      cur = {offset_trim_o, read_row_clock_o, x_start_load_o, y_start_load_o};
      nfs += frame_start_o;
      nend += column_end_pulse_o + read_row_end_pulse_o + shutter_row_end_pulse_o;
      ntr += cur[3] & ~prev[3];
      nxl += cur[1] & ~prev[1];
      nyl += cur[0] & ~prev[0];
      if (cur[2] && !prev[2])
      begin
        check("read_preset", row == 0, read_row_preset_o);
        check("shutter_preset", row == sh, shutter_row_preset_o);
        row++;
        col = 0;
      end
      if (pixel_valid_o === 1'b1)
      begin
        ey = ys + addr_t'(row - 1);
        ex = xs + addr_t'(col);
        check("pixel", {ey[4:0], ex[4:0]}, pixel_data_o);
        col++;
        npix++;
      end
      prev = cur;
    end
    check("rows", h, row);
    check("pixels", w * h, npix);
    check("frame_starts", 1, nfs);
    check("trims", 1, ntr);
    check("x_loads", 1, nxl);
    check("y_loads", 1, nyl);
    check("end_flags", ends, nend > 0);
    $display("frame test at x %0d y %0d done", xs, ys);
  endtask : frame_test

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    reset_test();
    frame_test(9'h003, 9'h005, 10'h003, 10'h002, 10'h001, 0);
    sensor.lag_ns = 20;
    frame_test(9'h1FF, 9'h1FF, 10'h001, 10'h001, 10'h000, 1);
    conclude();
  end

  // both frames take about 3200 cycles; allow several times that
  initial
  begin
    #(20000 * 4);
    n_errors++;
    conclude();
  end
endmodule : testbench
